// File: bench/mss_host_model.sv
// Host microcontroller model: serial clock and data line of the sensor port
`timescale 1ns/100ps
module mss_host_model (
  input wire logic mclk_i,
  input wire logic dut_d_i,
  input wire logic dut_oe_i,
  output logic sclk_o,
  output logic sdio_o,
  output logic rd_done_o,
  output logic [7:0] rd_byte_o
);
  logic drv_oe = 1'b1;
  logic drv_d = 1'b1;
  logic idle_d = 1'b0;
  initial begin
    sclk_o = 1'b1;
    rd_done_o = 1'b0;
    rd_byte_o = 8'h00;
  end
  // No pull on the line: a released line toggles so stale bits never pass
  always @(posedge mclk_i) idle_d <= ~idle_d;
  // Wire level from both enables
  assign sdio_o = dut_oe_i ? dut_d_i : (drv_oe ? drv_d : idle_d);
  // One transfer of n bits; clock idles high, data moves after each fall
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int n,
                      output logic [7:0] q);
    logic [15:0] bits;
    bits = {a, d};
    q = 8'h00;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      sclk_o <= 1'b0;
      if (i < 8 || a[7]) begin
        drv_oe <= 1'b1;
        drv_d <= bits[15-i];
      end
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b1;
      repeat (2) @(posedge mclk_i);
      // Sampled a cycle before the sensor sees the rise and drops its enable
      if (i >= 8 && !a[7]) q[15-i] = sdio_o;
      if (i == 7 && !a[7]) drv_oe <= 1'b0;
      @(posedge mclk_i);
    end
    if (n == 16 && !a[7]) begin
      @(posedge mclk_i);
      rd_byte_o <= q;
      rd_done_o <= 1'b1;
      @(posedge mclk_i);
      rd_done_o <= 1'b0;
    end
  endtask
endmodule // mss_host_model

// File: bench/mss_top_tb_top.sv
// Self-checking testbench of the sensor serial port and quadrature outputs
`timescale 1ns/100ps
module mss_top_tb_top;
  localparam int WDOG = 200;
  localparam int QDIV = 4;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic pd = 1'b0;
  logic frame = 1'b0;
  logic signed [7:0] dx = 8'sh00;
  logic signed [7:0] dy = 8'sh00;
  logic sclk, sdio_pin, sdio_d, sdio_oe, xa, xb, ya, yb, lowp, sleep, wstb, rd_done;
  logic [6:0] waddr, ta;
  logic [7:0] wdata, rd, td, q;
  logic [1:0] xl = 2'h0, yl = 2'h0, hold;
  logic [31:0] seed = 32'hA05A9F0A, r;
  logic [15:0] wq[$];
  logic [7:0] rq[$];
  logic [1:0] xq[$], yq[$];
  int fails = 0, samples_checked = 0, cyc = 0, xs = 0, ys = 0;
  always #12.5 mclk = ~mclk;
  mss_top #(.WDOG_CYCLES(WDOG), .QUAD_DIV(QDIV), .SLEEP_FRAMES(4)) dut_u (
    .mclk_i(mclk), .arst_n_i(arst_n), .sclk_i(sclk), .sdio_i(sdio_pin),
    .sdio_o(sdio_d), .sdio_oe_o(sdio_oe), .power_down_input_i(pd),
    .frame_strobe_i(frame), .delta_x_i(dx), .delta_y_i(dy),
    .x_phase_a_o(xa), .x_phase_b_o(xb), .y_phase_a_o(ya), .y_phase_b_o(yb),
    .low_power_o(lowp), .sleep_o(sleep), .wr_strobe_o(wstb),
    .wr_addr_o(waddr), .wr_data_o(wdata));
  mss_host_model host_u (.mclk_i(mclk), .dut_d_i(sdio_d), .dut_oe_i(sdio_oe),
    .sclk_o(sclk), .sdio_o(sdio_pin), .rd_done_o(rd_done), .rd_byte_o(rd));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Phase pair of a quadrature state: 00, 01, 11, 10
  function automatic logic [1:0] gray(input int s);
    return s[1] ? {1'b1, ~s[0]} : {1'b0, s[0]};
  endfunction
  task automatic check(input logic [15:0] e, input logic [15:0] a);
    samples_checked++;
    if (e !== a) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    wq.push_back({1'b0, a, d});
    host_u.xfer({1'b1, a}, d, 16, q);
  endtask
  task automatic rdq(input logic [6:0] a, input logic [7:0] e);
    rq.push_back(e);
    host_u.xfer({1'b0, a}, 8'h00, 16, q);
  endtask
  // One frame; expected steps are noted only when the frame counts
  task automatic frm(input logic signed [7:0] x, input logic signed [7:0] y, input logic mv);
    @(posedge mclk);
    dx <= x;
    dy <= y;
    frame <= 1'b1;
    @(posedge mclk);
    frame <= 1'b0;
    for (int i = 0; mv && i < (x < 0 ? -x : x); i++) begin
      xs = xs + (x < 0 ? -1 : 1);
      xq.push_back(gray(xs));
    end
    for (int i = 0; mv && i < (y < 0 ? -y : y); i++) begin
      ys = ys + (y < 0 ? -1 : 1);
      yq.push_back(gray(ys));
    end
  endtask
  task automatic wait_q();
    for (int i = 0; i < 3000 && (xq.size() + yq.size()) > 0; i++) @(posedge mclk);
  endtask
  // Result watcher, on the falling edge so outputs have settled
  always @(negedge mclk) begin
    if (arst_n) begin
      if (wstb) check(wq.pop_front(), {1'b0, waddr, wdata});
      if (rd_done) check(rq.pop_front(), rd);
      if ({xa, xb} !== xl) check(xq.pop_front(), {xa, xb});
      if ({ya, yb} !== yl) check(yq.pop_front(), {ya, yb});
    end
    xl <= {xa, xb};
    yl <= {ya, yb};
  end
  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check(2'h0, {xa, xb});
    check(2'h0, {ya, yb});
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      ta = {2'b11, r[4:0]};
      td = r[15:8];
      wr(ta, td);
      rdq(ta, td);
    end
    check(1'b0, sdio_oe);
    $display("test write and read back done");
    frm(8'sd5, -8'sd3, 1'b1);
    rdq(7'h02, 8'h80);
    wr(7'h03, 8'hA5);
    rdq(7'h03, 8'h05);
    rdq(7'h04, 8'hFD);
    rdq(7'h02, 8'h00);
    wait_q();
    $display("test motion done");
    frm(8'sd8, 8'sd0, 1'b1);
    repeat (3 * QDIV) @(posedge mclk);
    pd <= 1'b1;
    repeat (8) @(posedge mclk);
    hold = {xa, xb};
    check(1'b1, lowp);
    frm(8'sd2, 8'sd0, 1'b0);
    repeat (40) @(posedge mclk);
    check(hold, {xa, xb});
    pd <= 1'b0;
    wait_q();
    $display("test power-down hold done");
    host_u.xfer(8'hFF, 8'h00, 5, q);
    pd <= 1'b1;
    repeat (8) @(posedge mclk);
    pd <= 1'b0;
    repeat (8) @(posedge mclk);
    rdq(ta, td);
    host_u.xfer(8'hFF, 8'h00, 5, q);
    repeat (WDOG + 50) @(posedge mclk);
    rdq(ta, td);
    $display("test resync done");
    for (int i = 0; i < 5; i++) frm(8'sd0, 8'sd0, 1'b1);
    repeat (4) @(posedge mclk);
    check(1'b1, sleep);
    frm(8'sd1, 8'sd1, 1'b1);
    repeat (4) @(posedge mclk);
    check(1'b0, sleep);
    wait_q();
    repeat (20) @(posedge mclk);
    check(16'h0000, 16'(wq.size() + rq.size() + xq.size() + yq.size()));
    $display("test sleep done");
    finish_test();
  end
endmodule // mss_top_tb_top

// File: src/mss_pkg.sv
// Types shared by the motion sensor serial port and quadrature logic
package mss_pkg;
  // Serial port states, Gray coded along address, write, read
  typedef enum logic [1:0] {
    MSS_ST_ADDR = 2'h0,
    MSS_ST_WDATA = 2'h1,
    MSS_ST_RDATA = 2'h3
  } mss_state_t;
  // First byte of a transaction
  typedef struct packed {
    logic write;
    logic [6:0] addr;
  } mss_cmd_t;
  // Two phases of one quadrature axis
  typedef struct packed {
    logic a;
    logic b;
  } mss_quad_t;
endpackage

// File: src/mss_regs.svh
// Constants for the motion sensor serial port and quadrature outputs
`ifndef MSS_REGS_SVH
`define MSS_REGS_SVH
// Serial register addresses of the motion data
`define MSS_ADDR_MOTION 7'h02
`define MSS_ADDR_DELTA_X 7'h03
`define MSS_ADDR_DELTA_Y 7'h04
// Field positions
`define MSS_DIR_BIT 7
`define MSS_MOTION_BIT 7
// Reset values
`define MSS_QUAD_RST 2'h0
`define MSS_BYTE_RST 8'h00
// Timing: clock rate and serial watchdog timeout (1.7 ms kept in tenths)
`define MSS_CLK_KHZ 40000
`define MSS_WDOG_TIMEOUT_MS_X10 17
`define MSS_WDOG_CYCLES ((`MSS_WDOG_TIMEOUT_MS_X10 * `MSS_CLK_KHZ) / 10)
// Quadrature step divider and frames of no motion before sleep
`define MSS_QUAD_DIV 40
`define MSS_SLEEP_FRAMES 256
`endif

// File: src/mss_top.sv
// Motion sensor serial register port and two-axis quadrature outputs
// Function
// - Two-wire half duplex; data line changes follow clock falling edges.
// - Host alone starts transactions; sensor never begins one.
// - Two bytes: direction in bit 7 plus seven-bit address, then data.
// - Direction one is a write; host sends address and data bytes.
// - In a write the sensor samples data on rising clock edges.
// - Direction zero is a read; sensor returns the addressed register.
// - Sensor drives read data bits, each launched from a falling edge.
// - In reads the sensor's data bits change on falling edges; its driver turns off at the last rise.
// - Motion values are readable through serial registers too.
// - Power-down input puts the sensor in its low-power state.
// - Power-down input also resynchronises the serial port.
// - Per-frame X and Y displacements become two quadrature channels each.
// - Quadrature state machine starts in state 0 after reset.
// - Power-down holds quadrature state; it resumes where it stopped.
// - No motion enters power saving until motion returns.
// - Motionless axis keeps both quadrature outputs at last state.
// - Each single quadrature transition is exactly one count.
// - Positive X is right, positive Y is up, phase order follows.
// - Host releases before read turnaround; sensor drives, then releases.
// - Resync resets only the serial port; registers stay intact.
// - Clock idle past the 1.7 ms watchdog resets the serial port.
`timescale 1ns/100ps
`include "mss_regs.svh"

module mss_top #(
  parameter int DELTA_W = 8,
  parameter int PEND_W = 12,
  parameter int WDOG_CYCLES = `MSS_WDOG_CYCLES,
  parameter int QUAD_DIV = `MSS_QUAD_DIV,
  parameter int SLEEP_FRAMES = `MSS_SLEEP_FRAMES
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  input wire logic power_down_input_i,
  input wire logic frame_strobe_i,
  input wire logic signed [DELTA_W-1:0] delta_x_i,
  input wire logic signed [DELTA_W-1:0] delta_y_i,
  output logic x_phase_a_o,
  output logic x_phase_b_o,
  output logic y_phase_a_o,
  output logic y_phase_b_o,
  output logic low_power_o,
  output logic sleep_o,
  output logic wr_strobe_o,
  output logic [6:0] wr_addr_o,
  output logic [7:0] wr_data_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic sdio_s1_reg, sdio_s2_reg;
  logic pd_s1_reg, pd_s2_reg;

  // Two flops per pin; third sclk stage only feeds edge detection
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= 3'h7;
      {sdio_s1_reg, sdio_s2_reg} <= 2'h0;
      {pd_s1_reg, pd_s2_reg} <= 2'h0;
    end else begin
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= {sclk_i, sclk_s1_reg, sclk_s2_reg};
      {sdio_s1_reg, sdio_s2_reg} <= {sdio_i, sdio_s1_reg};
      {pd_s1_reg, pd_s2_reg} <= {power_down_input_i, pd_s1_reg};
    end
  end

  // Edges of the host clock; the sensor never drives it
  wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
  wire pd_on = pd_s2_reg;
  assign low_power_o = pd_on;

  // ----------------------------------------------------------------
  // Serial watchdog
  // ----------------------------------------------------------------
  logic [$clog2(WDOG_CYCLES+1)-1:0] wdog_reg;
  wire wdog_hit = (wdog_reg == ($clog2(WDOG_CYCLES+1))'(WDOG_CYCLES));

  // Any clock edge restarts it; it saturates, so the port stays cleared while the clock idles
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) wdog_reg <= '0;
    else if (sclk_rise | sclk_fall | pd_on) wdog_reg <= '0;
    else if (!wdog_hit) wdog_reg <= wdog_reg + 1'b1;
  end

  // Port resync sources: power-down level or a watchdog expiry
  wire port_clr = pd_on | wdog_hit;

  // ----------------------------------------------------------------
  // Serial port state machine
  // ----------------------------------------------------------------
  mss_pkg::mss_state_t state_reg, state_next;
  logic [2:0] bit_reg;
  logic [7:0] shift_reg;
  mss_pkg::mss_cmd_t cmd_reg;
  logic drive_reg;
  logic [7:0] rd_byte;

  // Decode of the byte boundary and of the direction flag
  wire last_bit = (bit_reg == 3'h7);
  wire [7:0] shift_in = {shift_reg[6:0], sdio_s2_reg};
  wire addr_done = (state_reg == mss_pkg::MSS_ST_ADDR) & sclk_rise & last_bit;
  wire is_write = shift_in[`MSS_DIR_BIT];
  wire wr_done = (state_reg == mss_pkg::MSS_ST_WDATA) & sclk_rise & last_bit;
  wire rd_done = (state_reg == mss_pkg::MSS_ST_RDATA) & sclk_rise & last_bit;

  // Next state: only host clock edges move it, so the sensor never starts one
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      mss_pkg::MSS_ST_ADDR: begin
        if (addr_done) state_next = is_write ? mss_pkg::MSS_ST_WDATA
                                             : mss_pkg::MSS_ST_RDATA;
      end
      mss_pkg::MSS_ST_WDATA: begin
        if (wr_done) state_next = mss_pkg::MSS_ST_ADDR;
      end
      mss_pkg::MSS_ST_RDATA: begin
        if (rd_done) state_next = mss_pkg::MSS_ST_ADDR;
      end
      default: state_next = mss_pkg::MSS_ST_ADDR;
    endcase
  end

  // State, bit count and command; resync clears only state and bit count, not the command or registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= mss_pkg::MSS_ST_ADDR;
      bit_reg <= 3'h0;
      cmd_reg <= '0;
    end else if (port_clr) begin
      state_reg <= mss_pkg::MSS_ST_ADDR;
      bit_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (sclk_rise) bit_reg <= bit_reg + 3'h1;
      if (addr_done) cmd_reg <= shift_in;
    end
  end

  // Shifter: samples on rising edges, loads read data at the turnaround fall
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) shift_reg <= `MSS_BYTE_RST;
    else if (state_reg == mss_pkg::MSS_ST_RDATA) begin
      if (sclk_fall && !drive_reg) shift_reg <= rd_byte;
      else if (sclk_fall) shift_reg <= {shift_reg[6:0], 1'b0};
    end else if (sclk_rise) shift_reg <= shift_in;
  end

  // Output enable: on at the fall after the address, off at the last rise
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) drive_reg <= 1'b0;
    else if (port_clr || rd_done) drive_reg <= 1'b0;
    else if (state_reg == mss_pkg::MSS_ST_RDATA && sclk_fall) drive_reg <= 1'b1;
  end

  // Read bit launched from a falling edge, held until the next one
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) sdio_o <= 1'b0;
    else if (state_reg == mss_pkg::MSS_ST_RDATA && sclk_fall) begin
      sdio_o <= drive_reg ? shift_reg[6] : rd_byte[7];
    end
  end
  assign sdio_oe_o = drive_reg;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] regs_mem [0:127];
  logic signed [DELTA_W-1:0] dx_reg, dy_reg;
  logic motion_reg;

  // Motion bytes are read-only; a write there is not stored, though its write notice still goes out; the rest is stored
  wire motion_addr = (cmd_reg.addr == `MSS_ADDR_MOTION) |
                     (cmd_reg.addr == `MSS_ADDR_DELTA_X) |
                     (cmd_reg.addr == `MSS_ADDR_DELTA_Y);
  wire wr_fire = wr_done & ~port_clr;

  // Array kept without reset: it is plain storage, not control state
  always_ff @(posedge mclk_i) begin
    if (wr_fire && !motion_addr) regs_mem[cmd_reg.addr] <= shift_in;
  end

  // Write notice to the rest of the chip
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_strobe_o <= 1'b0;
      wr_addr_o <= 7'h00;
      wr_data_o <= `MSS_BYTE_RST;
    end else begin
      wr_strobe_o <= wr_fire;
      if (wr_fire) begin
        wr_addr_o <= cmd_reg.addr;
        wr_data_o <= shift_in;
      end
    end
  end

  // Read-out selection; motion bytes come from the frame latches
  assign rd_byte = (cmd_reg.addr == `MSS_ADDR_MOTION) ? {motion_reg, 7'h00} :
                   (cmd_reg.addr == `MSS_ADDR_DELTA_X) ? 8'(dx_reg) :
                   (cmd_reg.addr == `MSS_ADDR_DELTA_Y) ? 8'(dy_reg) :
                   regs_mem[cmd_reg.addr];

  // Frame latches; a frame with motion wins over clear-on-read of the motion flag
  wire dx_read = rd_done & (cmd_reg.addr == `MSS_ADDR_DELTA_Y);
  wire frame_live = frame_strobe_i & ~pd_on;
  wire frame_moved = frame_live & ((delta_x_i != '0) | (delta_y_i != '0));
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dx_reg <= '0;
      dy_reg <= '0;
      motion_reg <= 1'b0;
    end else begin
      if (frame_live) begin
        dx_reg <= delta_x_i;
        dy_reg <= delta_y_i;
      end
      if (frame_moved) motion_reg <= 1'b1;
      else if (dx_read) motion_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power saving after frames without motion
  // ----------------------------------------------------------------
  logic [$clog2(SLEEP_FRAMES+1)-1:0] still_reg;
  wire still_full = (still_reg == ($clog2(SLEEP_FRAMES+1))'(SLEEP_FRAMES));

  // Counts quiet frames; any motion wakes at once
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) still_reg <= '0;
    else if (frame_moved) still_reg <= '0;
    else if (frame_live && !still_full) still_reg <= still_reg + 1'b1;
  end
  assign sleep_o = still_full;

  // ----------------------------------------------------------------
  // Quadrature step divider
  // ----------------------------------------------------------------
  logic [$clog2(QUAD_DIV)-1:0] div_reg;
  wire step_en = (div_reg == '0);

  // Limits the phase rate so a controller can follow each transition
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) div_reg <= '0;
    else if (step_en) div_reg <= ($clog2(QUAD_DIV))'(QUAD_DIV - 1);
    else div_reg <= div_reg - 1'b1;
  end

  // ----------------------------------------------------------------
  // Quadrature axes (0 is X, 1 is Y)
  // ----------------------------------------------------------------
  logic [1:0] qst [2];
  logic signed [PEND_W-1:0] pend [2];
  mss_pkg::mss_quad_t quad [2];
  wire signed [DELTA_W-1:0] delta_in [2];
  assign delta_in[0] = delta_x_i;
  assign delta_in[1] = delta_y_i;

  for (genvar ax = 0; ax < 2; ax++) begin : g_axis
    logic [1:0] qst_reg;
    logic signed [PEND_W-1:0] pend_reg;
    wire do_step = step_en & ~pd_on & (pend_reg != '0);
    wire up = ~pend_reg[PEND_W-1];
    wire signed [PEND_W-1:0] add_v = frame_live ? PEND_W'(delta_in[ax]) : '0;
    wire signed [PEND_W-1:0] sub_v = !do_step ? '0 : (up ? PEND_W'(1) : -PEND_W'(1));

    // Pending counts drain one per transition, in the sign's direction
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        qst_reg <= `MSS_QUAD_RST;
        pend_reg <= '0;
      end else begin
        pend_reg <= pend_reg + add_v - sub_v;
        if (do_step) qst_reg <= up ? qst_reg + 2'h1 : qst_reg - 2'h1;
      end
    end

    // Count to phases: 0,1,2,3 become 00,01,11,10
    assign quad[ax] = '{a: qst_reg[1], b: qst_reg[1] ^ qst_reg[0]};
    assign qst[ax] = qst_reg;
    assign pend[ax] = pend_reg;
  end

  assign x_phase_a_o = quad[0].a;
  assign x_phase_b_o = quad[0].b;
  assign y_phase_a_o = quad[1].a;
  assign y_phase_b_o = quad[1].b;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_turn_fall;
    (state_reg == mss_pkg::MSS_ST_RDATA) && sclk_fall && !drive_reg;
  endsequence

  drive_in_read_a: assert property (sdio_oe_o |-> state_reg == mss_pkg::MSS_ST_RDATA)
    else $error("data line driven outside read data phase");
  turn_on_a: assert property ((s_turn_fall and !port_clr) |=> sdio_oe_o)
    else $error("read turnaround did not enable driver");
  pd_release_a: assert property (pd_on |=> !sdio_oe_o
                                 && state_reg == mss_pkg::MSS_ST_ADDR)
    else $error("power-down did not resync serial port");
  bit_on_fall_a: assert property (sdio_oe_o && $changed(sdio_o) |-> $past(sclk_fall))
    else $error("read data changed away from a falling edge");
  wdog_reset_a: assert property (wdog_hit |=> state_reg == mss_pkg::MSS_ST_ADDR
                                 && bit_reg == 3'h0)
    else $error("watchdog did not reset serial port");
  write_after_16_a: assert property (wr_strobe_o |-> $past(state_reg) == mss_pkg::MSS_ST_WDATA
                                     && $past(sclk_rise) && $past(bit_reg) == 3'h7)
    else $error("write outside the data byte end");
  x_hold_pd_a: assert property (pd_on |=> $stable(qst[0]) && $stable(qst[1]))
    else $error("quadrature moved during power-down");
  x_one_step_a: assert property ($changed(qst[0]) |-> (qst[0] == $past(qst[0]) + 2'h1)
                                 || (qst[0] == $past(qst[0]) - 2'h1))
    else $error("x quadrature skipped a state");
  x_dir_pos_a: assert property (g_axis[0].do_step && pend[0] > 0
                                |=> qst[0] == $past(qst[0]) + 2'h1)
    else $error("positive x count stepped backward");
  y_dir_neg_a: assert property (g_axis[1].do_step && pend[1] < 0
                                |=> qst[1] == $past(qst[1]) - 2'h1)
    else $error("negative y count stepped forward");
  y_still_a: assert property (pend[1] == '0 |=> $stable(qst[1]))
    else $error("idle y axis changed phase");
  // A frame with motion must win over a same-cycle clear-on-read
  motion_set_a: assert property (frame_moved |=> motion_reg)
    else $error("motion flag lost to a same-cycle clear");

endmodule // mss_top
